/* pkg/scan_link_pkg.sv */
package scan_link_pkg;
	localparam int  FRAME_BITS   = 9;
	localparam int  DATA_BITS    = 8;
	localparam logic [7:0] BREAK_CHAR = 8'hBB;
	localparam logic [7:0] DELAY_CHAR = 8'hDB;
	localparam logic [7:0] EMPTY_CHAR = 8'hEB;
	localparam int  IR_BITS      = 4;
	localparam logic [3:0] DEBUG_LINK_SELECT_INSTR = 4'h7;
	localparam logic [3:0] IR_RESET_VALUE = 4'hF;
	localparam int  FIFO_DEPTH   = 32;
	localparam real LINK_CLK_PERIOD_NS = 48.0;

	typedef enum {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} tap_state_t;

	typedef struct packed {
		logic       parityError;
		logic       breakSeen;
		logic [7:0] data;
	} rx_word_t;
endpackage

/* sim/scan_port_debug_link_phy_bench.sv */
`timescale 1ns/10ps
module scan_port_debug_link_phy_bench;
	logic       clock = 1'b0;
	logic       reset = 1'b1;
	logic       fuse = 1'b1;
	logic       portOff = 1'b0;
	logic       txMode = 1'b0;
	logic [7:0] txData = 8'h00;
	logic       txValid = 1'b0;
	logic       rxReady = 1'b0;
	wire        testClk, testModeSel, testDataIn, testDataOut, testDataOutEn;
	wire        txTaken, rxValid, parityErr, breakDetect, errorState, linkTxMode;
	wire        linkSelected;
	wire  [7:0] rxData;
	int         failures = 0;
	int         nTests = 0;
	int         cntTaken = 0;
	int         cntPerr = 0;
	int         cntBreak = 0;
	int         cntRx = 0;
	int         cntEn = 0;
	logic       enLast = 1'b0;
	logic [8:0] got;

	always #2 clock = ~clock;

	scan_port_debug_link_phy DUT (
		.clock(clock), .reset(reset), .testClk(testClk), .testModeSel(testModeSel),
		.testDataIn(testDataIn), .testDataOut(testDataOut), .testDataOutEn(testDataOutEn),
		.scanPortEnableFuse(fuse), .scanPortDisable(portOff), .txMode(txMode),
		.txData(txData), .txValid(txValid), .txTaken(txTaken), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady), .parityErr(parityErr),
		.breakDetect(breakDetect), .errorState(errorState), .linkTxMode(linkTxMode),
		.linkSelected(linkSelected)
	);

	scan_programmer prog (
		.testClk(testClk), .testModeSel(testModeSel), .testDataIn(testDataIn),
		.testDataOut(testDataOut)
	);

	// pulses are counted so that a task can compare the change across a frame
	always @(posedge clock) begin
		enLast <= testDataOutEn;
		if (rxValid === 1'b1) cntRx <= cntRx + 1;
		if (testDataOutEn === 1'b1 && enLast !== 1'b1) cntEn <= cntEn + 1;
		if (txTaken === 1'b1) cntTaken <= cntTaken + 1;
		if (parityErr === 1'b1) cntPerr <= cntPerr + 1;
		if (breakDetect === 1'b1) cntBreak <= cntBreak + 1;
	end

	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", failures, nTests);
		if (failures == 0 && nTests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [8:0] seen, input logic [8:0] want, input string what);
		nTests++;
		if (seen !== want) begin
			failures++;
			$display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// rxValid only rises while the reader is ready, and then stands one cycle
	task automatic pop(input logic [7:0] want);
		int n;
		n = 0;
		@(posedge clock);
		rxReady <= 1'b1;
		do begin
			idle(1);
			n++;
		end while (rxValid !== 1'b1 && n < 100);
		if (rxValid !== 1'b1) begin
			failures++;
			finish_test();
		end
		check(rxData, want, "rx byte");
		@(posedge clock);
		rxReady <= 1'b0;
		idle(4);
	endtask

	// reader stands ready for a while; no word may arrive
	task automatic expect_none(input string what);
		int r0;
		r0 = cntRx;
		@(posedge clock);
		rxReady <= 1'b1;
		idle(8);
		@(posedge clock);
		rxReady <= 1'b0;
		idle(2);
		check(cntRx - r0, 9'h000, what);
	endtask

	task automatic s_reset();
		check({linkSelected, errorState, linkTxMode, rxValid}, 4'h0, "after reset");
		prog.reset_tap();
		prog.load_ir(scan_link_pkg::DEBUG_LINK_SELECT_INSTR);
		idle(6);
		check(linkSelected, 1'b1, "selected");
	endtask

	task automatic s_rx();
		int e0;
		e0 = cntEn;
		prog.frame(prog.data_char(8'h35), got);
		check(got, prog.special_char(scan_link_pkg::EMPTY_CHAR), "empty");
		check(cntEn - e0, 9'h001, "tdo driven once");
		check(testDataOutEn, 1'b0, "tdo released");
		pop(8'h35);
	endtask

	task automatic s_tx();
		int t0;
		@(posedge clock);
		txMode <= 1'b1;
		idle(4);
		check(linkTxMode, 1'b1, "tx mode");
		prog.frame(prog.data_char(8'h00), got);
		check(got, prog.special_char(scan_link_pkg::DELAY_CHAR), "delay");
		t0 = cntTaken;
		@(posedge clock);
		txData <= 8'hC8;
		txValid <= 1'b1;
		prog.fetch(got);
		check(got, {1'b1, 8'hC8}, "tx byte");
		check(cntTaken - t0, 9'h001, "taken");
		@(posedge clock);
		txValid <= 1'b0;
		txMode <= 1'b0;
		idle(4);
		expect_none("no rx in tx");
	endtask

	// fill past the depth with the reader stalled, then drain in order
	task automatic s_fifo();
		int p0;
		p0 = cntPerr;
		for (int i = 0; i <= scan_link_pkg::FIFO_DEPTH; i++)
			prog.frame(prog.data_char(8'h40 + i[7:0]), got);
		idle(4);
		check(cntPerr - p0, 9'h001, "overflow");
		for (int i = 0; i < scan_link_pkg::FIFO_DEPTH; i++) pop(8'h40 + i[7:0]);
		expect_none("drained");
	endtask

	task automatic s_error_break();
		int p0;
		int b0;
		p0 = cntPerr;
		prog.frame(prog.special_char(8'h21), got);
		idle(6);
		check(cntPerr - p0, 9'h001, "parity error");
		check(errorState, 1'b1, "error state");
		expect_none("bad byte dropped");
		b0 = cntBreak;
		prog.send_break(got);
		idle(6);
		check(cntBreak - b0, 9'h001, "break");
		check({errorState, linkTxMode}, 2'h0, "recovered");
		prog.frame(prog.data_char(8'h00), got);
		check(got, prog.special_char(scan_link_pkg::EMPTY_CHAR), "rx after break");
		pop(8'h00);
	endtask

	task automatic s_disable();
		@(posedge clock);
		portOff <= 1'b1;
		idle(6);
		check(linkSelected, 1'b0, "disabled");
		@(posedge clock);
		portOff <= 1'b0;
		fuse <= 1'b0;
		idle(6);
		check(linkSelected, 1'b0, "fuse off");
		@(posedge clock);
		fuse <= 1'b1;
		prog.reset_tap();
		prog.load_ir(scan_link_pkg::DEBUG_LINK_SELECT_INSTR);
		idle(6);
		check(linkSelected, 1'b1, "reenabled");
	endtask

	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		idle(2);
		s_reset();
		s_rx();
		s_tx();
		s_fifo();
		s_error_break();
		s_disable();
		finish_test();
	end
endmodule

/* sim/scan_programmer.sv */
`timescale 1ns/10ps
module scan_programmer (
	output logic      testClk,
	output logic      testModeSel,
	output logic      testDataIn,
	input  wire logic testDataOut
);
	logic tdoBit;

	initial begin
		testClk = 1'b0;
		testModeSel = 1'b1;
		testDataIn = 1'b1;
	end

	// clock stands low between steps; callers pass the inverse when data is unused
	task automatic step(input logic tms, input logic tdi);
		testModeSel = tms;
		testDataIn = tdi;
		#(scan_link_pkg::LINK_CLK_PERIOD_NS / 2.0) testClk = 1'b1;
		tdoBit = testDataOut;
		#(scan_link_pkg::LINK_CLK_PERIOD_NS / 2.0) testClk = 1'b0;
	endtask

	task automatic reset_tap();
		repeat (5) step(1'b1, ~testDataIn);
		step(1'b0, ~testDataIn);
	endtask

	task automatic load_ir(input logic [3:0] code);
		step(1'b1, ~testDataIn);
		step(1'b1, ~testDataIn);
		step(1'b0, ~testDataIn);
		step(1'b0, ~testDataIn);
		for (int i = 0; i < 4; i++) step(i == 3, code[i]);
		step(1'b1, ~testDataIn);
		step(1'b0, ~testDataIn);
	endtask

	task automatic frame(input logic [8:0] inBits, output logic [8:0] outBits);
		step(1'b1, ~testDataIn);
		step(1'b0, ~testDataIn);
		step(1'b0, ~testDataIn);
		for (int i = 0; i < 9; i++) begin
			step(i == 8, inBits[i]);
			outBits[i] = tdoBit;
		end
		step(1'b1, ~testDataIn);
		step(1'b0, ~testDataIn);
	endtask

	function automatic logic [8:0] data_char(input logic [7:0] d);
		return {^d, d};
	endfunction

	function automatic logic [8:0] special_char(input logic [7:0] d);
		return {~^d, d};
	endfunction

	task automatic send_break(output logic [8:0] got);
		frame(special_char(scan_link_pkg::BREAK_CHAR), got);
	endtask

	// a delay answer means retry the frame, never reissue the load
	task automatic fetch(output logic [8:0] got);
		frame(data_char(8'h00), got);
		for (int n = 0; n < 8 && got === special_char(scan_link_pkg::DELAY_CHAR); n++)
			frame(data_char(8'h00), got);
	endtask
endmodule

/* src/scan_fifo.sv */
`timescale 1ns/10ps
module scan_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_ff;
	logic [AW:0]      rdPtr_ff;
	logic             doWrite;
	logic             doRead;

	assign inReady  = (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
	assign outValid = wrPtr_ff != rdPtr_ff;
	assign outData  = mem[rdPtr_ff[AW-1:0]];
	assign doWrite  = inValid && inReady;
	assign doRead   = outValid && outReady;

	always_ff @(posedge clock) begin
		if (doWrite)
			mem[wrPtr_ff[AW-1:0]] <= inData;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
		end else if (flush) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
		end else begin
			if (doWrite)
				wrPtr_ff <= wrPtr_ff + 1'b1;
			if (doRead)
				rdPtr_ff <= rdPtr_ff + 1'b1;
		end
	end
endmodule

/* src/scan_port_debug_link_phy.sv */
`timescale 1ns/10ps
// Overview of operation
// - debug-link instruction selects 9-bit register
// - Capture-DR loads controller-offered value
// - Shift-DR shifts one bit per test clock
// - Update-DR latches received byte to controller
// - frame: eight data bits, parity, LSB first
// - normal frame parity is even
// - special characters carry inverted parity
// - device sends delay 0xDB when not ready
// - device sends empty 0xEB in receive
// - exactly one of transmit or receive
// - change on falling, sample on rising edge
// - transmit loads byte, appends generated parity
// - pending transmit loads valid byte, even parity
// - receive mode loads empty, parity set
// - transmit without data loads delay, parity set
// - receive nine bits, pass valid byte on
// - check even parity, flag mismatch
// - check always; parity error matching break
// - usable only when fuse set, disable clear
// - disable bit turns interface off
// - exception: error state until break
module scan_port_debug_link_phy #(
	parameter int FIFO_WORDS = scan_link_pkg::FIFO_DEPTH
) (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       testClk,
	input  wire logic       testModeSel,
	input  wire logic       testDataIn,
	output logic            testDataOut,
	output logic            testDataOutEn,
	input  wire logic       scanPortEnableFuse,
	input  wire logic       scanPortDisable,
	input  wire logic       txMode,
	input  wire logic [7:0] txData,
	input  wire logic       txValid,
	output logic            txTaken,
	output logic [7:0]      rxData,
	output logic            rxValid,
	input  wire logic       rxReady,
	output logic            parityErr,
	output logic            breakDetect,
	output logic            errorState,
	output logic            linkTxMode,
	output logic            linkSelected
);
	// pins from the programmer's domain: two flops before use
	logic [1:0] tckSync_ff;
	logic [1:0] tmsSync_ff;
	logic [1:0] tdiSync_ff;
	logic       tckLast_ff;
	logic       tckRise;
	logic       tckFall;
	logic       portOn;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			tckSync_ff <= '0;
			tmsSync_ff <= '0;
			tdiSync_ff <= '0;
			tckLast_ff <= 1'b0;
		end else begin
			tckSync_ff <= {tckSync_ff[0], testClk};
			tmsSync_ff <= {tmsSync_ff[0], testModeSel};
			tdiSync_ff <= {tdiSync_ff[0], testDataIn};
			tckLast_ff <= tckSync_ff[1];
		end
	end

	assign tckRise = tckSync_ff[1] && !tckLast_ff;
	assign tckFall = !tckSync_ff[1] && tckLast_ff;
	assign portOn  = scanPortEnableFuse && !scanPortDisable;

	scan_link_pkg::tap_state_t tap_ff;
	scan_link_pkg::tap_state_t nxt_tap;

	always_comb begin
		nxt_tap = tap_ff;
		case (tap_ff)
			scan_link_pkg::TAP_RESET:    nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_RESET
								: scan_link_pkg::TAP_IDLE;
			scan_link_pkg::TAP_IDLE:     nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_SEL_DR
								: scan_link_pkg::TAP_IDLE;
			scan_link_pkg::TAP_SEL_DR:   nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_SEL_IR
								: scan_link_pkg::TAP_CAP_DR;
			scan_link_pkg::TAP_CAP_DR:   nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_EXIT1_DR
								: scan_link_pkg::TAP_SHIFT_DR;
			scan_link_pkg::TAP_SHIFT_DR: nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_EXIT1_DR
								: scan_link_pkg::TAP_SHIFT_DR;
			scan_link_pkg::TAP_EXIT1_DR: nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_UPD_DR
								: scan_link_pkg::TAP_PAUSE_DR;
			scan_link_pkg::TAP_PAUSE_DR: nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_EXIT2_DR
								: scan_link_pkg::TAP_PAUSE_DR;
			scan_link_pkg::TAP_EXIT2_DR: nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_UPD_DR
								: scan_link_pkg::TAP_SHIFT_DR;
			scan_link_pkg::TAP_UPD_DR:   nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_SEL_DR
								: scan_link_pkg::TAP_IDLE;
			scan_link_pkg::TAP_SEL_IR:   nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_RESET
								: scan_link_pkg::TAP_CAP_IR;
			scan_link_pkg::TAP_CAP_IR:   nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_EXIT1_IR
								: scan_link_pkg::TAP_SHIFT_IR;
			scan_link_pkg::TAP_SHIFT_IR: nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_EXIT1_IR
								: scan_link_pkg::TAP_SHIFT_IR;
			scan_link_pkg::TAP_EXIT1_IR: nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_UPD_IR
								: scan_link_pkg::TAP_PAUSE_IR;
			scan_link_pkg::TAP_PAUSE_IR: nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_EXIT2_IR
								: scan_link_pkg::TAP_PAUSE_IR;
			scan_link_pkg::TAP_EXIT2_IR: nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_UPD_IR
								: scan_link_pkg::TAP_SHIFT_IR;
			scan_link_pkg::TAP_UPD_IR:   nxt_tap = tmsSync_ff[1] ? scan_link_pkg::TAP_SEL_DR
								: scan_link_pkg::TAP_IDLE;
			default:                     nxt_tap = scan_link_pkg::TAP_RESET;
		endcase
	end

	// controller steps only on sampled rising test clock; held in reset while the port is off
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			tap_ff <= scan_link_pkg::TAP_RESET;
		else if (!portOn)
			tap_ff <= scan_link_pkg::TAP_RESET;
		else if (tckRise)
			tap_ff <= nxt_tap;
	end

	logic [scan_link_pkg::IR_BITS-1:0] irShift_ff;
	logic [scan_link_pkg::IR_BITS-1:0] instr_ff;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			irShift_ff <= '0;
			instr_ff   <= scan_link_pkg::IR_RESET_VALUE;
		end else if (!portOn || tap_ff == scan_link_pkg::TAP_RESET) begin
			instr_ff   <= scan_link_pkg::IR_RESET_VALUE;
		end else if (tckRise) begin
			if (tap_ff == scan_link_pkg::TAP_CAP_IR)
				irShift_ff <= scan_link_pkg::IR_BITS'(1);
			else if (tap_ff == scan_link_pkg::TAP_SHIFT_IR)
				irShift_ff <= {tdiSync_ff[1], irShift_ff[scan_link_pkg::IR_BITS-1:1]};
			else if (tap_ff == scan_link_pkg::TAP_UPD_IR)
				instr_ff <= irShift_ff;
		end
	end

	logic selected;
	assign selected = portOn && instr_ff == scan_link_pkg::DEBUG_LINK_SELECT_INSTR;

	// mode flags: never both set, both clear in receive
	logic txMode_ff;
	logic errState_ff;
	logic [8:0] dr_ff;
	logic       frameEvt;
	logic [7:0] rxByte;
	logic       rxParBad;
	logic       rxIsBreak;
	logic       fifoInReady;
	logic       haveTx;

	assign rxByte    = dr_ff[7:0];
	assign rxParBad  = (^rxByte) != dr_ff[8];
	assign rxIsBreak = rxParBad && rxByte == scan_link_pkg::BREAK_CHAR;
	assign frameEvt  = selected && tckRise && tap_ff == scan_link_pkg::TAP_UPD_DR;
	assign haveTx    = txValid && txMode_ff;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			txMode_ff   <= 1'b0;
			errState_ff <= 1'b0;
		end else if (!portOn) begin
			txMode_ff   <= 1'b0;
			errState_ff <= 1'b0;
		end else if (frameEvt && rxIsBreak) begin
			txMode_ff   <= 1'b0;
			errState_ff <= 1'b0;
		end else if (frameEvt && rxParBad) begin
			txMode_ff   <= 1'b0;
			errState_ff <= 1'b1;
		end else if (!errState_ff) begin
			txMode_ff   <= txMode;
		end
	end

	// capture and shift of the 9-bit register
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			dr_ff <= '0;
		end else if (selected && tckRise) begin
			if (tap_ff == scan_link_pkg::TAP_CAP_DR) begin
				if (haveTx)
					dr_ff <= {^txData, txData};
				else if (txMode_ff)
					dr_ff <= {~^scan_link_pkg::DELAY_CHAR, scan_link_pkg::DELAY_CHAR};
				else
					dr_ff <= {~^scan_link_pkg::EMPTY_CHAR, scan_link_pkg::EMPTY_CHAR};
			end else if (tap_ff == scan_link_pkg::TAP_SHIFT_DR) begin
				dr_ff <= {tdiSync_ff[1], dr_ff[8:1]};
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			txTaken <= 1'b0;
		else
			txTaken <= selected && tckRise && tap_ff == scan_link_pkg::TAP_CAP_DR && haveTx;
	end

	// output changes after the falling edge, lsb leaves first
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			testDataOut   <= 1'b0;
			testDataOutEn <= 1'b0;
		end else if (tckFall) begin
			testDataOut   <= dr_ff[0];
			testDataOutEn <= selected && tap_ff == scan_link_pkg::TAP_SHIFT_DR;
		end
	end

	// received bytes queue toward the controller; full fifo drops and flags
	scan_link_pkg::rx_word_t fifoIn;
	scan_link_pkg::rx_word_t fifoOut;
	logic fifoOutValid;
	logic pushRx;

	assign fifoIn = '{parityError: rxParBad, breakSeen: rxIsBreak, data: rxByte};
	assign pushRx = frameEvt && !txMode_ff && !rxParBad && !errState_ff;

	scan_fifo #(
		.WIDTH ($bits(scan_link_pkg::rx_word_t)),
		.DEPTH (FIFO_WORDS)
	) rxFifo (
		.clock    (clock),
		.reset    (reset),
		.flush    (frameEvt && rxIsBreak),
		.inData   (fifoIn),
		.inValid  (pushRx),
		.inReady  (fifoInReady),
		.outData  (fifoOut),
		.outValid (fifoOutValid),
		.outReady (rxReady && !rxValid)
	);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rxValid <= 1'b0;
			rxData  <= '0;
		end else if (rxValid && rxReady) begin
			rxValid <= 1'b0;
		end else if (!rxValid && rxReady && fifoOutValid) begin
			rxValid <= 1'b1;
			rxData  <= fifoOut.data;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			parityErr   <= 1'b0;
			breakDetect <= 1'b0;
		end else begin
			parityErr   <= frameEvt && (rxParBad || (pushRx && !fifoInReady));
			breakDetect <= frameEvt && rxIsBreak;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			errorState   <= 1'b0;
			linkTxMode   <= 1'b0;
			linkSelected <= 1'b0;
		end else begin
			errorState   <= errState_ff;
			linkTxMode   <= txMode_ff;
			linkSelected <= selected;
		end
	end

	property p_break_resets_mode;
		@(posedge clock) disable iff (reset)
		(frameEvt && rxIsBreak) |=> !txMode_ff && !errState_ff;
	endproperty
	a_break_resets_mode: assert property (p_break_resets_mode)
		else $error("break did not return to receive");

	property p_parity_err_enters_error;
		@(posedge clock) disable iff (reset)
		(frameEvt && rxParBad && !rxIsBreak) |=> errState_ff ##1 errorState;
	endproperty
	a_parity_err_enters_error: assert property (p_parity_err_enters_error)
		else $error("parity error missed error state");

	property p_capture_rx_empty;
		@(posedge clock) disable iff (reset)
		(selected && tckRise && tap_ff == scan_link_pkg::TAP_CAP_DR && !txMode_ff)
		|=> dr_ff == {1'b1, scan_link_pkg::EMPTY_CHAR};
	endproperty
	a_capture_rx_empty: assert property (p_capture_rx_empty)
		else $error("empty character not captured");

	property p_capture_delay;
		@(posedge clock) disable iff (reset)
		(selected && tckRise && tap_ff == scan_link_pkg::TAP_CAP_DR && txMode_ff && !txValid)
		|=> dr_ff == {1'b1, scan_link_pkg::DELAY_CHAR};
	endproperty
	a_capture_delay: assert property (p_capture_delay)
		else $error("delay character not captured");

	property p_capture_valid;
		@(posedge clock) disable iff (reset)
		(selected && tckRise && tap_ff == scan_link_pkg::TAP_CAP_DR && haveTx)
		|=> (^dr_ff == 1'b0) && txTaken;
	endproperty
	a_capture_valid: assert property (p_capture_valid)
		else $error("valid byte parity wrong");

	property p_shift_lsb;
		@(posedge clock) disable iff (reset)
		(selected && tckRise && tap_ff == scan_link_pkg::TAP_SHIFT_DR)
		|=> dr_ff[8] == $past(tdiSync_ff[1]) && dr_ff[7:0] == $past(dr_ff[8:1]);
	endproperty
	a_shift_lsb: assert property (p_shift_lsb)
		else $error("shift register misbehaved");

	property p_tdo_on_fall;
		@(posedge clock) disable iff (reset)
		!tckFall |=> $stable(testDataOut);
	endproperty
	a_tdo_on_fall: assert property (p_tdo_on_fall)
		else $error("output changed off falling edge");

	property p_disabled_idle;
		@(posedge clock) disable iff (reset)
		!portOn |=> !selected ##1 !linkSelected;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle)
		else $error("port active while disabled");

	property p_valid_rx_pushed;
		@(posedge clock) disable iff (reset)
		pushRx |=> parityErr == !$past(fifoInReady) && !breakDetect;
	endproperty
	a_valid_rx_pushed: assert property (p_valid_rx_pushed)
		else $error("receive flags wrong");
endmodule
